//--- shared/emc_defines.svh
`ifndef EMC_DEFINES_SVH
`define EMC_DEFINES_SVH
`define EMC_BYTE_W 8
`define EMC_FIFO_DEPTH 16
`define EMC_BIT_LAST 3'h7
`define EMC_BIT_ZERO 3'h0
`define EMC_MCLK_PERIOD_NS 20
`define EMC_TXCLK_HALF_NS 320
`define EMC_TXCLK_HALF_CYC ((`EMC_TXCLK_HALF_NS + `EMC_MCLK_PERIOD_NS - 1) / `EMC_MCLK_PERIOD_NS)
`define EMC_DIV_W 5
`define EMC_LINE_MARK 1'b1
`endif

//--- shared/emc_pkg.sv
package emc_pkg;
	typedef enum logic {EMC_TX_IDLE, EMC_TX_SHIFT} emc_tx_e;
	typedef logic [7:0] emc_byte_t;
endpackage

//--- design/emc_fifo.sv
`timescale 1ns/1ns
module emc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_q;
	logic [AW:0] rdPtr_q;
	logic full;
	logic empty;
	assign empty = (wrPtr_q == rdPtr_q);
	assign full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr_q[AW-1:0]];
	always_ff @(posedge clk)
	begin
		if (inValid && !full)
			mem[wrPtr_q[AW-1:0]] <= inData;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			wrPtr_q <= '0;
		else if (inValid && !full)
			wrPtr_q <= wrPtr_q + 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			rdPtr_q <= '0;
		else if (outReady && !empty)
			rdPtr_q <= rdPtr_q + 1'b1;
	end
endmodule

//--- design/emc_modem_ctl.sv
`timescale 1ns/1ns
`include "emc_defines.svh"
module emc_modem_ctl (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic rxElemClk,
	input wire logic rxDataPin,
	input wire logic txElemClkPin,
	input wire logic dsrPin,
	input wire logic ringPin,
	output logic txDataOut_q,
	output logic txClkOut_q,
	output logic dtrOut_q,
	output logic loopOut_q,
	input wire logic dtrRequest,
	input wire logic switchedMode,
	input wire logic loopbackReq,
	input wire logic txClkInternal,
	input wire logic [7:0] txByte,
	input wire logic txValid,
	output logic txReady_q,
	output emc_pkg::emc_byte_t rxByte_q,
	output logic rxValid_q,
	input wire logic rxReady,
	output logic rxOverrun_q,
	input wire logic overrunClr,
	output logic dsrStatus_q,
	output logic ringInd_q,
	output logic dtrBlocked_q
);
	import emc_pkg::*;

	function automatic logic rise(input logic cur, input logic prev);
		rise = cur && !prev;
	endfunction

	// link domain: receive element clock, falling edge is element centre
	logic rstLinkMeta;
	logic rstLink;
	logic [2:0] rxBitCnt_q;
	logic [7:0] rxShift_q;
	emc_byte_t rxHold_q;
	logic rxTgl_q;
	always_ff @(negedge rxElemClk)
	begin
		rstLinkMeta <= sys_rst;
		rstLink <= rstLinkMeta;
	end
	always_ff @(negedge rxElemClk)
	begin
		if (rstLink)
		begin
			rxBitCnt_q <= `EMC_BIT_ZERO;
			rxShift_q <= '0;
		end
		else
		begin
			rxShift_q <= {rxDataPin, rxShift_q[7:1]};
			rxBitCnt_q <= rxBitCnt_q + 1'b1;
		end
	end
	always_ff @(negedge rxElemClk)
	begin
		if (rstLink)
		begin
			rxTgl_q <= 1'b0;
			rxHold_q <= '0;
		end
		else if (rxBitCnt_q == `EMC_BIT_LAST)
		begin
			rxHold_q <= {rxDataPin, rxShift_q[7:1]};
			rxTgl_q <= !rxTgl_q;
		end
	end

	// synchronisers into mclk
	logic dsrMeta;
	logic dsrSync;
	logic ringMeta;
	logic tgMeta;
	logic tgSync;
	logic tgPrev;
	logic tckMeta;
	logic tckSync;
	logic tckPrev;
	always_ff @(posedge mclk)
	begin
		dsrMeta <= dsrPin;
		dsrSync <= dsrMeta;
		ringMeta <= ringPin;
		ringInd_q <= ringMeta;
		tgMeta <= rxTgl_q;
		tgSync <= tgMeta;
		tgPrev <= tgSync;
		tckMeta <= txElemClkPin;
		tckSync <= tckMeta;
		tckPrev <= tckSync;
	end
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			dsrStatus_q <= 1'b0;
		else
			dsrStatus_q <= dsrSync;
	end

	// receive data and modem element clock count only with set-ready on, or in local loopback
	logic dsrUse;
	assign dsrUse = dsrSync || loopOut_q;

	// receive bytes into fifo
	logic rxPulse;
	logic pushValid;
	logic pushReady;
	logic fifoValid;
	emc_byte_t fifoData;
	logic popReady;
	assign rxPulse = tgSync ^ tgPrev;
	assign pushValid = rxPulse && dsrUse;
	assign popReady = !rxValid_q || rxReady;
	emc_fifo #(.WIDTH(`EMC_BYTE_W), .DEPTH(`EMC_FIFO_DEPTH)) uFifo (
		.clk(mclk),
		.rst(sys_rst),
		.inValid(pushValid),
		.inReady(pushReady),
		.inData(rxHold_q),
		.outValid(fifoValid),
		.outReady(popReady),
		.outData(fifoData)
	);
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rxValid_q <= 1'b0;
			rxByte_q <= '0;
		end
		else if (popReady)
		begin
			rxValid_q <= fifoValid;
			rxByte_q <= fifoData;
		end
	end
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			rxOverrun_q <= 1'b0;
		else if (pushValid && !pushReady)
			rxOverrun_q <= 1'b1;
		else if (overrunClr)
			rxOverrun_q <= 1'b0;
	end

	// terminal ready and switched-line re-assert hold-off
	logic dtrDrop;
	assign dtrDrop = dtrOut_q && !dtrRequest;
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			dtrOut_q <= 1'b0;
		else if (!dtrRequest)
			dtrOut_q <= 1'b0;
		else if (!dtrBlocked_q)
			dtrOut_q <= 1'b1;
	end
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			dtrBlocked_q <= 1'b0;
		else if (dtrDrop && switchedMode)
			dtrBlocked_q <= 1'b1;
		else if (!dsrSync)
			dtrBlocked_q <= 1'b0;
	end
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			loopOut_q <= 1'b0;
		else
			loopOut_q <= loopbackReq;
	end

	// transmit clock: internal divider or modem element clock
	logic [`EMC_DIV_W-1:0] divCnt_q;
	logic divTick;
	logic launch;
	assign divTick = (divCnt_q == `EMC_DIV_W'(`EMC_TXCLK_HALF_CYC - 1));
	always_ff @(posedge mclk)
	begin
		if (sys_rst || divTick)
			divCnt_q <= '0;
		else
			divCnt_q <= divCnt_q + 1'b1;
	end
	always_ff @(posedge mclk)
	begin
		if (sys_rst || !txClkInternal)
			txClkOut_q <= 1'b0;
		else if (divTick)
			txClkOut_q <= !txClkOut_q;
	end
	assign launch = txClkInternal ? (divTick && !txClkOut_q) : (rise(tckSync, tckPrev) && dsrUse);

	// transmit shifter
	emc_tx_e txState_q;
	logic [7:0] txShift_q;
	logic [2:0] txBitCnt_q;
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			txState_q <= EMC_TX_IDLE;
			txReady_q <= 1'b0;
			txShift_q <= '0;
			txBitCnt_q <= `EMC_BIT_ZERO;
		end
		else
		begin
			unique case (txState_q)
				EMC_TX_IDLE:
				begin
					txReady_q <= 1'b1;
					if (txValid && txReady_q)
					begin
						txShift_q <= txByte;
						txBitCnt_q <= `EMC_BIT_ZERO;
						txReady_q <= 1'b0;
						txState_q <= EMC_TX_SHIFT;
					end
				end
				EMC_TX_SHIFT:
				begin
					if (launch)
					begin
						txShift_q <= {1'b0, txShift_q[7:1]};
						txBitCnt_q <= txBitCnt_q + 1'b1;
						if (txBitCnt_q == `EMC_BIT_LAST)
							txState_q <= EMC_TX_IDLE;
					end
				end
			endcase
		end
	end
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			txDataOut_q <= `EMC_LINE_MARK;
		else if (launch)
			txDataOut_q <= (txState_q == EMC_TX_SHIFT) ? txShift_q[0] : `EMC_LINE_MARK;
	end

	sequence sDropWhileReady;
		(switchedMode && dsrSync && dtrOut_q && !dtrRequest) ##1 !dtrOut_q;
	endsequence
	sequence sIntRise;
		txClkInternal && divTick && !txClkOut_q;
	endsequence

	AST_RX_BYTE: assert property (@(negedge rxElemClk) disable iff (rstLink)
		rxBitCnt_q == `EMC_BIT_LAST |=> rxTgl_q != $past(rxTgl_q) && rxHold_q[7] == $past(rxDataPin))
		else $error("received byte not captured at element centre");
	AST_DTR_ON: assert property (@(posedge mclk) disable iff (sys_rst)
		dtrRequest && !dtrBlocked_q ##1 dtrRequest |-> dtrOut_q)
		else $error("terminal ready not asserted on request");
	AST_DTR_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
		sDropWhileReady |-> dtrBlocked_q ##1 (dtrBlocked_q || !$past(dsrSync)) && !dtrOut_q)
		else $error("terminal ready re-asserted before set-ready dropped");
	AST_TX_EDGE: assert property (@(posedge mclk) disable iff (sys_rst)
		txDataOut_q != $past(txDataOut_q) |-> $past(launch))
		else $error("transmit data changed away from clock rising edge");
	AST_TXCLK_INT: assert property (@(posedge mclk) disable iff (sys_rst)
		sIntRise ##1 txClkInternal |-> txClkOut_q ##[1:16] !txClkOut_q)
		else $error("internal transmit clock not driven out");
	AST_DSR_GATE: assert property (@(posedge mclk) disable iff (sys_rst)
		rxPulse && !dsrSync && !loopOut_q |-> !pushValid ##1 $stable(uFifo.wrPtr_q))
		else $error("receive data accepted while set-ready off");
	AST_SYNC_DSR: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(dsrSync) |-> $past(dsrPin, 2) ##1 dsrStatus_q)
		else $error("set-ready acted on without two-stage sync");
endmodule

//--- test/emc_modem_model.sv
`timescale 1ns/1ns
module emc_modem_model (
	output logic rxElemClk,
	output logic rxDataPin,
	output logic dsrPin,
	input wire logic dtrOut,
	input wire logic loopOut,
	input wire logic holdDsr,
	input wire logic txData,
	input wire logic txClk,
	output logic [7:0] txSeen
);
	logic [3:0] txCnt;
	initial
	begin
		rxElemClk = 1'b0;
		#7;
		forever #32 rxElemClk = ~rxElemClk;
	end
	initial rxDataPin = 1'b1;
	initial txCnt = 4'h0;
	initial txSeen = 8'h00;
	// set-ready follows terminal ready or holdDsr, forced off in loopback
	assign dsrPin = (dtrOut | holdDsr) & ~loopOut;
	// zeros while connected, transmit looped back in loopback
	always @(posedge rxElemClk)
		rxDataPin <= loopOut ? txData : ~dsrPin;
	// capture eight bits from the first zero, lsb first
	always @(negedge txClk)
		if (txCnt != 4'h0 || txData == 1'b0)
		begin
			txSeen <= {txData, txSeen[7:1]};
			txCnt <= (txCnt == 4'h7) ? 4'h0 : txCnt + 4'h1;
		end
endmodule

//--- test/tb.sv
`timescale 1ns/1ns
module tb;
	logic mclk = 1'b0;
	logic sysRst = 1'b1;
	logic rxElemClk, rxDataPin, dsrPin, ringPin, txDataOut, txClkOut, dtrOut, loopOut, dtrRequest, switchedMode;
	logic loopbackReq, txClkInternal, txValid, txReady, rxValid, rxReady, rxOverrun, overrunClr, dsrStatus;
	logic ringInd, dtrBlocked, holdDsr;
	logic [7:0] txByte, txSeen;
	emc_pkg::emc_byte_t rxByte;
	int mismatches = 0;
	int checks = 0;
	logic [4:0] rows [4] = '{5'h15, 5'h1E, 5'h00, 5'h15};
	always #10 mclk = ~mclk;
	emc_modem_model i_modem (.rxElemClk(rxElemClk), .rxDataPin(rxDataPin), .dsrPin(dsrPin), .dtrOut(dtrOut),
		.loopOut(loopOut), .holdDsr(holdDsr), .txData(txDataOut), .txClk(txClkOut), .txSeen(txSeen));
	emc_modem_ctl i_dut (.mclk(mclk), .sys_rst(sysRst), .rxElemClk(rxElemClk), .rxDataPin(rxDataPin),
		.txElemClkPin(rxElemClk), .dsrPin(dsrPin), .ringPin(ringPin), .txDataOut_q(txDataOut),
		.txClkOut_q(txClkOut), .dtrOut_q(dtrOut), .loopOut_q(loopOut), .dtrRequest(dtrRequest),
		.switchedMode(switchedMode), .loopbackReq(loopbackReq), .txClkInternal(txClkInternal), .txByte(txByte),
		.txValid(txValid), .txReady_q(txReady), .rxByte_q(rxByte), .rxValid_q(rxValid), .rxReady(rxReady),
		.rxOverrun_q(rxOverrun), .overrunClr(overrunClr), .dsrStatus_q(dsrStatus), .ringInd_q(ringInd),
		.dtrBlocked_q(dtrBlocked));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task idle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task pop();
		int n;
		n = 0;
		while (rxValid !== 1'b1 && n < 60)
		begin
			idle(1);
			n++;
		end
		chk({7'h00, rxValid}, 8'h01);
		chk(rxByte, 8'h00);
		rxReady = 1'b1;
		idle(1);
		rxReady = 1'b0;
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#200000;
		mismatches++;
		finish_test();
	end
	initial
	begin
		{dtrRequest, switchedMode, loopbackReq, txClkInternal, txValid, rxReady, overrunClr, holdDsr, ringPin} = '0;
		txByte = 8'h00;
		idle(8);
		sysRst = 1'b0;
		idle(2);
		chk({7'h00, txDataOut}, 8'h01);
		// terminal ready and loopback rows
		for (int i = 0; i < 4; i++)
		begin
			{dtrRequest, loopbackReq} = rows[i][4:3];
			idle(8);
			chk({5'h00, dtrOut, loopOut, dsrStatus}, {5'h00, rows[i][2:0]});
		end
		// fill the fifo until it refuses, then drain
		rxReady = 1'b1;
		idle(100);
		rxReady = 1'b0;
		idle(600);
		chk({7'h00, rxOverrun}, 8'h01);
		repeat (16) pop();
		overrunClr = 1'b1;
		idle(1);
		overrunClr = 1'b0;
		idle(1);
		chk({7'h00, rxOverrun}, 8'h00);
		// transmit on the internal clock
		txClkInternal = 1'b1;
		txByte = 8'h5A;
		txValid = 1'b1;
		idle(1);
		txValid = 1'b0;
		chk({7'h00, txReady}, 8'h00);
		idle(340);
		chk(txSeen, 8'h5A);
		chk({7'h00, txReady}, 8'h01);
		// switched re-assert held off until set-ready drops
		switchedMode = 1'b1;
		holdDsr = 1'b1;
		dtrRequest = 1'b0;
		idle(4);
		dtrRequest = 1'b1;
		idle(8);
		chk({6'h00, dtrOut, dtrBlocked}, 8'h01);
		holdDsr = 1'b0;
		idle(8);
		chk({7'h00, dtrOut}, 8'h01);
		// set-ready off: data ignored, ring still seen
		dtrRequest = 1'b0;
		switchedMode = 1'b0;
		ringPin = 1'b1;
		rxReady = 1'b1;
		idle(100);
		rxReady = 1'b0;
		idle(200);
		chk({6'h00, rxValid, ringInd}, 8'h01);
		finish_test();
	end
endmodule
